// [ocrfd_core.sv]
`timescale 1ns/1ps
`include "ocrfd_map.svh"

// Overview of operation
// - Fine magnitude is bits 15:7, unsigned, about 0.1 ps per code.
// - Zero fine and zero coarse magnitude together add no sample clock delay.
// - Fine register at Fh, write only, resets to 0x007f, bits 6:0 ones.
// - Target bit 0 delays I clock, 1 delays Q; other stays fixed.
// - Auto phase align ignores manual delays and keeps edges 180 degrees apart.
// - Positive and negative zero offsets differ by a tenth LSB.
// - Realign pulse resets output clock to sample clock phase.
// - Realign sampled on clk rising edge; output clock held at mode-chosen level.
// - Output clock may show one short pulse when realign asserts.
// - After release, phase realigns on next sample clock rising edge.
// - Output clock restarts after the fixed normal latency.
module ocrfd_core
    import ocrfd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        output_clock_realign,
    input  wire logic        calibration_active,
    input  wire logic        ddr_mode,
    input  wire logic        output_edge,
    input  wire logic        offset_sign_neg,
    input  wire logic [7:0]  offset_magnitude,
    output logic             output_data_clock,
    output logic             realign_busy,
    output logic [11:0]      i_clock_delay,
    output logic [11:0]      q_clock_delay,
    output logic             auto_phase_active,
    output logic             cal_conflict,
    output logic [9:0]       offset_code
);
    // ***************************************************************
    // Registers
    // ***************************************************************
    ocrfd_wr_t    wr;
    logic [15:0]  fine_delay_reg;
    logic [15:0]  coarse_delay_reg;
    logic [15:0]  des_enable_reg;
    ocrfd_delay_t dly;
    assign wr = '{we: wr_en, addr: wr_addr, data: wr_data};

    wire fine_hit   = wr.we && wr.addr == `OCRFD_ADDR_FINE_DELAY;
    wire coarse_hit = wr.we && wr.addr == `OCRFD_ADDR_COARSE_DELAY;
    wire enable_hit = wr.we && wr.addr == `OCRFD_ADDR_DES_ENABLE;

    // The low bits are stored as written; software is expected to write ones.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fine_delay_reg   <= `OCRFD_FINE_RESET;
            coarse_delay_reg <= `OCRFD_COARSE_RESET;
            des_enable_reg   <= `OCRFD_ENABLE_RESET;
        end else begin
            if (fine_hit) begin
                fine_delay_reg <= wr.data;
            end
            if (coarse_hit) begin
                coarse_delay_reg <= wr.data;
            end
            if (enable_hit) begin
                des_enable_reg <= wr.data;
            end
        end
    end

    assign dly.fine_mag   = fine_delay_reg[`OCRFD_FINE_MAG_MSB:`OCRFD_FINE_MAG_LSB];
    assign dly.coarse_mag = coarse_delay_reg[`OCRFD_COARSE_MAG_MSB:`OCRFD_COARSE_MAG_LSB];
    assign dly.target_q   = coarse_delay_reg[`OCRFD_TARGET_BIT];
    assign dly.auto_phase = des_enable_reg[`OCRFD_AUTO_PHASE_BIT];

    // ***************************************************************
    // Sample clock delay
    // ***************************************************************
    // Delay is in fine steps; a coarse step is taken as 200 fine steps,
    // although the true ratio drifts with device conditions.
    logic [11:0] manual_delay;
    logic [11:0] i_delay_next;
    logic [11:0] q_delay_next;
    assign manual_delay = 12'({dly.coarse_mag} * 12'h0c8) + {3'h0, dly.fine_mag};
    assign i_delay_next = (dly.auto_phase || dly.target_q) ? 12'h0 : manual_delay;
    assign q_delay_next = (dly.auto_phase || !dly.target_q) ? 12'h0 : manual_delay;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            i_clock_delay     <= 12'h0;
            q_clock_delay     <= 12'h0;
            auto_phase_active <= 1'b0;
        end else begin
            i_clock_delay     <= i_delay_next;
            q_clock_delay     <= q_delay_next;
            auto_phase_active <= dly.auto_phase;
        end
    end

    // ***************************************************************
    // Output clock realignment
    // ***************************************************************
    ocrfd_state_t state_reg;
    ocrfd_state_t state_next;
    logic [3:0]   lat_reg;
    logic [3:0]   lat_next;
    logic         div_reg;
    logic         div_next;
    logic         output_data_clock_next;
    wire          hold_level = ddr_mode ^ output_edge;

    always_comb begin
        state_next = state_reg;
        lat_next   = lat_reg;
        case (state_reg)
            OCRFD_RUN: begin
                if (output_clock_realign) begin
                    state_next = OCRFD_HOLD;
                end
            end
            OCRFD_HOLD: begin
                if (!output_clock_realign) begin
                    state_next = OCRFD_ALIGN;
                end
            end
            // A realign seen in this single cycle is ignored here; WAIT takes it only if still asserted one cycle later.
            OCRFD_ALIGN: begin
                lat_next   = `OCRFD_OUT_LATENCY;
                state_next = OCRFD_WAIT;
            end
            OCRFD_WAIT: begin
                if (output_clock_realign) begin
                    state_next = OCRFD_HOLD;
                end else if (lat_reg == 4'h1) begin
                    state_next = OCRFD_RUN;
                end else begin
                    lat_next = lat_reg - 4'h1;
                end
            end
            default: state_next = OCRFD_RUN;
        endcase
    end

    // Divider phase restarts at the realign point so every device matches.
    assign div_next  = (state_reg == OCRFD_RUN) ? ~div_reg : 1'b0;
    // Forcing the hold level mid-cycle may clip one pulse short.
    assign output_data_clock_next = (output_clock_realign || state_reg != OCRFD_RUN) ? hold_level
                     : (ddr_mode ? ~div_reg : div_reg) ^ output_edge;

    // The conflict flag is sticky until reset, because a spoiled calibration stays spoiled.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg         <= OCRFD_RUN;
            lat_reg           <= 4'h0;
            div_reg           <= 1'b0;
            output_data_clock <= 1'b0;
            realign_busy      <= 1'b0;
            cal_conflict      <= 1'b0;
        end else begin
            state_reg         <= state_next;
            lat_reg           <= lat_next;
            div_reg           <= div_next;
            output_data_clock <= output_data_clock_next;
            realign_busy      <= state_next != OCRFD_RUN;
            cal_conflict      <= cal_conflict | (output_clock_realign & calibration_active);
        end
    end

    // The offset trim lives in its own module so its sign handling stays separate.
    ocrfd_offset_adj u_offset (
        .clk        (clk),
        .rst        (rst),
        .sign_neg   (offset_sign_neg),
        .magnitude  (offset_magnitude),
        .offset_reg (offset_code)
    );

    // ***************************************************************
    // Checks
    // ***************************************************************
    chk_fine_reset_value: assert property (@(posedge clk)
        $fell(rst) |-> fine_delay_reg == 16'h007f)
        else $error("fine delay reset value wrong");
    chk_zero_no_delay: assert property (@(posedge clk) disable iff (rst)
        (dly.fine_mag == 9'h0 && dly.coarse_mag == 3'h0) |=> (i_clock_delay == 12'h0
        && q_clock_delay == 12'h0))
        else $error("delay applied with zero magnitude");
    chk_target_fixed: assert property (@(posedge clk) disable iff (rst)
        (!dly.auto_phase && dly.target_q) |=> i_clock_delay == 12'h0)
        else $error("I clock moved while Q targeted");
    chk_auto_ignores: assert property (@(posedge clk) disable iff (rst)
        dly.auto_phase |=> (i_clock_delay == 12'h0 && q_clock_delay == 12'h0))
        else $error("manual delay used in auto phase mode");
    chk_fine_only_write: assert property (@(posedge clk) disable iff (rst)
        fine_hit |=> $stable(coarse_delay_reg) && $stable(des_enable_reg))
        else $error("fine write changed other registers");
    chk_hold_level: assert property (@(posedge clk) disable iff (rst)
        output_clock_realign |=> output_data_clock == $past(hold_level))
        else $error("output clock not held during realign");
    chk_restart_latency: assert property (@(posedge clk) disable iff (rst)
        (state_reg == OCRFD_HOLD && !output_clock_realign) ##1 !output_clock_realign [*5]
        |=> state_reg == OCRFD_RUN)
        else $error("output clock restart latency wrong");
    chk_realign_enter: assert property (@(posedge clk) disable iff (rst)
        (state_reg == OCRFD_RUN && output_clock_realign) |=> realign_busy)
        else $error("realign pulse not taken");
    chk_cal_flag: assert property (@(posedge clk) disable iff (rst)
        (output_clock_realign && calibration_active) |=> cal_conflict)
        else $error("calibration conflict not flagged");
    chk_cal_sticky: assert property (@(posedge clk) disable iff (rst)
        cal_conflict |=> cal_conflict)
        else $error("calibration conflict flag cleared");
    chk_divider_restart: assert property (@(posedge clk) disable iff (rst)
        (state_reg == OCRFD_WAIT && state_next == OCRFD_RUN) |=> (div_reg == 1'b0
        && output_data_clock == $past(hold_level)))
        else $error("divider phase not restarted at realign");

    cov_realign: cover property (@(posedge clk) disable iff (rst)
        state_reg == OCRFD_WAIT ##1 state_reg == OCRFD_RUN);
    cov_fine_write: cover property (@(posedge clk) disable iff (rst) fine_hit);
    cov_q_target: cover property (@(posedge clk) disable iff (rst) q_clock_delay != 12'h0);
    cov_cal_conflict: cover property (@(posedge clk) disable iff (rst) $rose(cal_conflict));
endmodule

// [ocrfd_map.svh]
`ifndef OCRFD_MAP_SVH
`define OCRFD_MAP_SVH

// ***************************************************************
// Register map
// ***************************************************************
`define OCRFD_ADDR_FINE_DELAY   4'hf
`define OCRFD_ADDR_COARSE_DELAY 4'he
`define OCRFD_ADDR_DES_ENABLE   4'hd
`define OCRFD_FINE_RESET        16'h007f
`define OCRFD_COARSE_RESET      16'h07ff
`define OCRFD_ENABLE_RESET      16'h3fff
`define OCRFD_FINE_MAG_MSB      15
`define OCRFD_FINE_MAG_LSB      7
`define OCRFD_COARSE_MAG_MSB    13
`define OCRFD_COARSE_MAG_LSB    11
`define OCRFD_TARGET_BIT        14
`define OCRFD_AUTO_PHASE_BIT    14
`define OCRFD_OFFSET_ZERO_STEP  2'h1

// ***************************************************************
// Timing
// ***************************************************************
`define OCRFD_FINE_STEP_FS      100
`define OCRFD_OUT_LATENCY       4'h4

`endif

// [ocrfd_offset_adj.sv]
`timescale 1ns/1ps
`include "ocrfd_map.svh"

module ocrfd_offset_adj
    import ocrfd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sign_neg,
    input  wire logic [7:0] magnitude,
    output logic      [9:0] offset_reg
);
    // ***************************************************************
    // Offset in tenths of an LSB
    // ***************************************************************
    // Positive and negative zero differ by one tenth step.
    logic [9:0] offset_next;
    assign offset_next = sign_neg ? 10'h0 - {magnitude, 2'h0} - 10'({`OCRFD_OFFSET_ZERO_STEP})
                                  : {magnitude, 2'h0};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            offset_reg <= 10'h0;
        end else begin
            offset_reg <= offset_next;
        end
    end

    chk_zero_sign_step: assert property (@(posedge clk) disable iff (rst)
        (sign_neg && magnitude == 8'h0) |=> offset_reg != 10'h0)
        else $error("negative zero offset equals positive zero");
endmodule

// [ocrfd_pkg.sv]
package ocrfd_pkg;
    typedef struct packed {
        logic [8:0] fine_mag;
        logic [2:0] coarse_mag;
        logic       target_q;
        logic       auto_phase;
    } ocrfd_delay_t;

    typedef struct packed {
        logic        we;
        logic [3:0]  addr;
        logic [15:0] data;
    } ocrfd_wr_t;

    typedef enum logic [1:0] {
        OCRFD_RUN   = 2'b00,
        OCRFD_HOLD  = 2'b01,
        OCRFD_ALIGN = 2'b10,
        OCRFD_WAIT  = 2'b11
    } ocrfd_state_t;
endpackage

// [ocrfd_sysctl.sv]
`timescale 1ns/1ps

module ocrfd_sysctl (
    input  wire logic clk,
    output logic      output_clock_realign,
    output logic      calibration_active
);
    // Set when a pulse gave up waiting for calibration to end; the bench counts it as a fault.
    logic wait_expired;

    initial begin
        output_clock_realign = 1'b0;
        calibration_active   = 1'b0;
        wait_expired         = 1'b0;
    end

    // ********************
    // Realign pulse
    // ********************
    // Called right after a rising edge; the pulse is released on a later rising edge.
    // A real controller defers the pulse until calibration ends; force_cal breaks that on purpose.
    task automatic pulse(input int width, input bit force_cal);
        int guard;
        begin
            guard = 0;
            while (calibration_active && !force_cal && guard < 100) begin
                @(posedge clk);
                guard++;
            end
            if (guard >= 100) begin
                wait_expired <= 1'b1;
            end
            output_clock_realign <= 1'b1;
            repeat (width) @(posedge clk);
            output_clock_realign <= 1'b0;
        end
    endtask

    task automatic calibrate(input int cycles);
        begin
            calibration_active <= 1'b1;
            repeat (cycles) @(posedge clk);
            calibration_active <= 1'b0;
        end
    endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "ocrfd_map.svh"
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end

module testbench
    import ocrfd_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    ocrfd_wr_t   wr_bus = '0;
    logic        ddr_mode = 1'b0;
    logic        output_edge = 1'b0;
    logic        offset_sign_neg = 1'b0;
    logic [7:0]  offset_magnitude = 8'h00;
    logic        output_clock_realign;
    logic        calibration_active;
    logic        output_data_clock;
    logic        realign_busy;
    logic [11:0] i_clock_delay;
    logic [11:0] q_clock_delay;
    logic        auto_phase_active;
    logic        cal_conflict;
    logic [9:0]  offset_code;
    logic [31:0] seed = 32'h8b58;
    int          n_errors = 0;
    int          n_tests = 0;
    int          k;
    logic [8:0]  fine;
    logic [2:0]  coarse;
    logic        tgt;
    logic        hold;
    logic [11:0] dly;

    initial begin
        forever #20 clk = ~clk;
    end

    ocrfd_core DUT (.clk(clk), .rst(rst), .wr_en(wr_bus.we), .wr_addr(wr_bus.addr),
        .wr_data(wr_bus.data), .output_clock_realign(output_clock_realign),
        .calibration_active(calibration_active), .ddr_mode(ddr_mode),
        .output_edge(output_edge), .offset_sign_neg(offset_sign_neg),
        .offset_magnitude(offset_magnitude), .output_data_clock(output_data_clock),
        .realign_busy(realign_busy), .i_clock_delay(i_clock_delay),
        .q_clock_delay(q_clock_delay), .auto_phase_active(auto_phase_active),
        .cal_conflict(cal_conflict), .offset_code(offset_code));

    ocrfd_sysctl sys (.clk(clk), .output_clock_realign(output_clock_realign),
        .calibration_active(calibration_active));

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // A negative code sits one tenth below its positive twin, so -(4m+1) is ~(4m).
    function automatic logic [9:0] exp_offset(input logic neg, input logic [7:0] mag);
        return neg ? ~{mag, 2'b00} : {mag, 2'b00};
    endfunction

    // One coarse step is taken as 200 fine steps.
    function automatic logic [11:0] exp_delay(input logic [8:0] f, input logic [2:0] c);
        return 12'(f) + 12'(c) * 12'h0c8;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        begin
            wr_bus <= '{we: 1'b1, addr: a, data: d};
            @(posedge clk);
            wr_bus.we <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask

    task automatic chk_delay;
        begin
            dly = exp_delay(fine, coarse);
            `CHK("i_clock_delay", (tgt ? 12'h000 : dly), i_clock_delay)
            `CHK("q_clock_delay", (tgt ? dly : 12'h000), q_clock_delay)
        end
    endtask

    task automatic realign_run(input logic d, input logic e);
        begin
            ddr_mode <= d;
            output_edge <= e;
            hold = d ^ e;
            seed = xs(seed);
            repeat (2) @(posedge clk);
            sys.pulse(2 + int'(seed[1:0]), 1'b0);
            #1;
            `CHK("hold level", hold, output_data_clock)
            `CHK("realign_busy", 1'b1, realign_busy)
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
                if (realign_busy === 1'b1) `CHK("held clock", hold, output_data_clock)
            end while (realign_busy === 1'b1 && k < 20);
            `CHK("restart edges", 2 + `OCRFD_OUT_LATENCY, k)
            `CHK("restart phase", hold, output_data_clock)
            @(posedge clk);
            #1;
            `CHK("first run level", hold, output_data_clock)
            @(posedge clk);
            #1;
            `CHK("toggle", ~hold, output_data_clock)
            @(posedge clk);
        end
    endtask

    task automatic report_and_stop;
        begin
            $display("Checks %0d, errors %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask

    // ********************
    // Scenarios
    // ********************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        fine = 9'h000;
        coarse = 3'h0;
        tgt = 1'b0;
        chk_delay;
        `CHK("auto phase", 1'b0, auto_phase_active)
        @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            fine = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : seed[8:0];
            coarse = (i < 2) ? 3'(i * 7) : seed[11:9];
            tgt = seed[12];
            wr(`OCRFD_ADDR_COARSE_DELAY, {1'b0, tgt, coarse, 11'h7ff});
            @(posedge clk);
            wr(`OCRFD_ADDR_FINE_DELAY, {fine, 7'h7f});
            chk_delay;
            @(posedge clk);
            wr(seed[13] ? 4'h3 : `OCRFD_ADDR_DES_ENABLE, seed[13] ? ~{fine, 7'h00} : 16'h3fff);
            chk_delay;
            @(posedge clk);
        end
        wr(`OCRFD_ADDR_DES_ENABLE, 16'h7fff);
        `CHK("auto phase", 1'b1, auto_phase_active)
        `CHK("auto i delay", 12'h000, i_clock_delay)
        `CHK("auto q delay", 12'h000, q_clock_delay)
        @(posedge clk);
        wr(`OCRFD_ADDR_DES_ENABLE, 16'h3fff);
        `CHK("auto phase", 1'b0, auto_phase_active)
        chk_delay;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            offset_sign_neg <= (i < 2) ? i[0] : seed[7];
            offset_magnitude <= (i < 2) ? 8'h00 : {1'b0, seed[6:0]};
            @(posedge clk);
            #1;
            `CHK("offset", exp_offset(offset_sign_neg, offset_magnitude), offset_code)
            @(posedge clk);
        end
        for (int i = 0; i < 4; i++) begin
            realign_run(i[1], i[0]);
        end
        fork
            sys.calibrate(6);
            begin
                @(posedge clk);
                sys.pulse(2, 1'b0);
            end
        join
        repeat (10) @(posedge clk);
        #1;
        `CHK("cal_conflict", 1'b0, cal_conflict)
        @(posedge clk);
        fork
            sys.calibrate(6);
            begin
                @(posedge clk);
                sys.pulse(2, 1'b1);
            end
        join
        repeat (10) @(posedge clk);
        #1;
        `CHK("cal_conflict", 1'b1, cal_conflict)
        `CHK("controller wait", 1'b0, sys.wait_expired)
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
endmodule
